/* File: verilog/kpi_keypad_pin_interrupt.sv */
/*
 Keypad pin interrupt unit: eight key inputs, polarity on the upper four and pin enables,
 edge-only or edge-and-level detection, shared event flag, APB slave and a
 sticky interrupt status block. Assumes an APB master on pclk and pins that
 are not yet synchronous; deep_sleep_state comes from the power controller.
*/
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "kpi_defines.svh"

module kpi_keypad_pin_interrupt (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] key_pins,
   input wire logic deep_sleep_state,
   input wire logic [7:0] port_pull_en,
   output logic key_irq_req,
   output logic irq,
   output logic [7:0] pull_down_sel,
   output logic [7:0] force_input,
   output logic wake_req
);

   function automatic kpi_pkg::kpi_reg_t kpi_decode(input logic [7:0] a);
      case (a)
         `KPI_OFF_SC: kpi_decode = kpi_pkg::KPI_REG_SC;
         `KPI_OFF_PE: kpi_decode = kpi_pkg::KPI_REG_PE;
         `KPI_OFF_IST: kpi_decode = kpi_pkg::KPI_REG_IST;
         `KPI_OFF_ICLR: kpi_decode = kpi_pkg::KPI_REG_ICLR;
         `KPI_OFF_IEN: kpi_decode = kpi_pkg::KPI_REG_IEN;
         default: kpi_decode = kpi_pkg::KPI_REG_NONE;
      endcase
   endfunction : kpi_decode

   kpi_sync_if sif ();

   kpi_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .sif(sif)
   );

   assign sif.raw = key_pins;

   logic [3:0] pol_q;
   kpi_pkg::kpi_pins_t pe_q;
   logic mode_q;
   logic key_irq_enable_q;
   logic flag_q;
   logic flag_d;
   logic [1:0] ien_q;
   logic [1:0] ist_q;
   logic [1:0] ist_d;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic key_irq_q;
   logic irq_q;
   logic [7:0] pull_down_q;
   logic [7:0] force_in_q;

   kpi_pkg::kpi_pins_t pol_eff;
   kpi_pkg::kpi_pins_t asrt;
   kpi_pkg::kpi_pins_t en_asrt;
   kpi_pkg::kpi_pins_t edge_vec;
   kpi_pkg::kpi_pins_t prev_deasrt_q;
   kpi_pkg::kpi_reg_t sel;
   logic any_edge;
   logic edge_set;
   logic level_hold;
   logic ack;
   logic access;
   logic wr_acc;
   logic rd_load;
   logic wake_level;

   // Lower nibble has no polarity storage at all
   assign pol_eff = {pol_q, 4'h0};
   assign asrt = ~(sif.synced ^ pol_eff);
   assign en_asrt = asrt & pe_q;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_pin
         // Armed only by an enabled, deasserted sample one cycle earlier
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prev_deasrt_q[i] <= 1'b0;
            end else begin
               prev_deasrt_q[i] <= pe_q[i] & ~asrt[i];
            end
         end
         assign edge_vec[i] = pe_q[i] & asrt[i] & prev_deasrt_q[i];
      end
   endgenerate

   assign any_edge = |edge_vec;

   // Clocks are gone in deep sleep, so synchronous edge detection is ignored
   always_comb begin
      if (deep_sleep_state) begin
         edge_set = 1'b0;
      end else if (mode_q) begin
         edge_set = any_edge && ((en_asrt & ~edge_vec) == 8'h00);
      end else begin
         edge_set = any_edge;
      end
   end

   assign level_hold = mode_q & (|en_asrt);

   assign access = psel & penable & pready_q;
   assign wr_acc = access & pwrite;
   assign rd_load = psel & penable & ~pready_q;
   assign sel = kpi_decode(paddr);
   assign ack = wr_acc && (sel == kpi_pkg::KPI_REG_SC) && pwdata[`KPI_SC_ACK_BIT];

   // Set and level hold both win over acknowledge
   assign flag_d = edge_set | level_hold | (flag_q & ~ack);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= `KPI_RST_SC_BIT;
      end else begin
         flag_q <= flag_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_q <= `KPI_RST_POL;
         mode_q <= `KPI_RST_SC_BIT;
         key_irq_enable_q <= `KPI_RST_SC_BIT;
         pe_q <= `KPI_RST_PE;
         ien_q <= `KPI_RST_IEN;
      end else if (wr_acc) begin
         case (sel)
            kpi_pkg::KPI_REG_SC: begin
               pol_q <= pwdata[`KPI_SC_POL_HI:`KPI_SC_POL_LO];
               key_irq_enable_q <= pwdata[`KPI_SC_IE_BIT];
               mode_q <= pwdata[`KPI_SC_MODE_BIT];
            end
            kpi_pkg::KPI_REG_PE: begin
               pe_q <= pwdata[7:0];
            end
            kpi_pkg::KPI_REG_IEN: begin
               ien_q <= pwdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Sticky events; a clear in the same cycle as a set loses
   assign wake_level = deep_sleep_state & (|en_asrt);
   always_comb begin
      ist_d = ist_q;
      if (wr_acc && (sel == kpi_pkg::KPI_REG_ICLR)) begin
         ist_d = ist_q & ~pwdata[1:0];
      end
      if (edge_set) begin
         ist_d[`KPI_IST_EDGE_BIT] = 1'b1;
      end
      if (wake_level) begin
         ist_d[`KPI_IST_WAKE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= 2'h0;
      end else begin
         ist_q <= ist_d;
      end
   end

   // One wait state so that read data comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= rd_load;
         pslverr_q <= rd_load && (sel == kpi_pkg::KPI_REG_NONE);
         if (rd_load && !pwrite) begin
            case (sel)
               kpi_pkg::KPI_REG_SC: begin
                  // Acknowledge position always reads zero
                  prdata_q <= {24'h00_0000, pol_q, flag_q, 1'b0, key_irq_enable_q, mode_q};
               end
               kpi_pkg::KPI_REG_PE: begin
                  prdata_q <= {24'h00_0000, pe_q};
               end
               kpi_pkg::KPI_REG_IST: begin
                  prdata_q <= {30'h0000_0000, ist_q};
               end
               kpi_pkg::KPI_REG_IEN: begin
                  prdata_q <= {30'h0000_0000, ien_q};
               end
               default: begin
                  prdata_q <= 32'h0000_0000;
               end
            endcase
         end else if (!rd_load) begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_irq_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         key_irq_q <= flag_q & key_irq_enable_q;
         irq_q <= |(ist_q & ien_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pull_down_q <= 8'h00;
         force_in_q <= 8'h00;
      end else begin
         pull_down_q <= pe_q & pol_eff & port_pull_en;
         force_in_q <= pe_q;
      end
   end

   // Must work with pclk stopped, so this path is combinational on raw pins
   assign wake_req = deep_sleep_state & (|(pe_q & ~(key_pins ^ pol_eff)));

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign key_irq_req = key_irq_q;
   assign irq = irq_q;
   assign pull_down_sel = pull_down_q;
   assign force_input = force_in_q;

   logic [1:0] up_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end

   chk_flag_edge_set:
   assert property (@(posedge pclk) disable iff (!presetn) edge_set |=> flag_q)
      else $error("flag not set after edge");

   chk_ack_clears_flag:
   assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q && ack && !edge_set && !level_hold) |=> !flag_q)
      else $error("acknowledge did not clear flag");

   chk_level_holds_flag:
   assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q && (|en_asrt)) |=> flag_q)
      else $error("flag dropped while enabled pin asserted");

   chk_irq_follows_flag:
   assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (key_irq_req == ($past(flag_q) && $past(key_irq_enable_q))))
      else $error("interrupt request mismatch");

   chk_mode_edge_only:
   assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_q && !deep_sleep_state && any_edge) |-> edge_set)
      else $error("edge lost in edge-only mode");

   chk_disabled_ignored:
   assert property (@(posedge pclk) disable iff (!presetn) (edge_vec & ~pe_q) == 8'h00)
      else $error("disabled pin produced edge");

   chk_falling_edge_seen:
   assert property (@(posedge pclk) disable iff (!presetn)
      (pe_q[0] && $past(pe_q[0]) && $past(sif.synced[0]) && !sif.synced[0]) |-> edge_vec[0])
      else $error("falling edge missed");

   chk_rising_edge_seen:
   assert property (@(posedge pclk) disable iff (!presetn)
      (pe_q[7] && $past(pe_q[7]) && pol_q[3] && $past(pol_q[3])
       && !$past(sif.synced[7]) && sif.synced[7]) |-> edge_vec[7])
      else $error("rising edge missed");

   chk_low_pins_fixed:
   assert property (@(posedge pclk) disable iff (!presetn)
      (up_q == 2'h3 && pe_q[3] && $past(pe_q[3]) && !$past(sif.synced[3])) |-> !edge_vec[3])
      else $error("low pin edge without deasserted sample");

   chk_armed_first:
   assert property (@(posedge pclk) disable iff (!presetn)
      edge_vec[5] |-> ($past(pe_q[5]) && !$past(asrt[5])))
      else $error("edge without prior deasserted level");

   chk_level_mode_edge:
   assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q && edge_set) |-> ((en_asrt & ~edge_vec) == 8'h00))
      else $error("level mode edge with other pin asserted");

   chk_sleep_bypass:
   assert property (@(posedge pclk) disable iff (!presetn)
      deep_sleep_state |-> (!edge_set && (wake_req ==
         ((|(pe_q[3:0] & ~key_pins[3:0])) || (|(pe_q[7:4] & ~(key_pins[7:4] ^ pol_q)))))))
      else $error("deep sleep path wrong");

   chk_pull_down_sel:
   assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (pull_down_sel == ($past(pe_q) & {$past(pol_q), 4'h0} & $past(port_pull_en))))
      else $error("pulldown select wrong");

   chk_force_input:
   assert property (@(posedge pclk) disable iff (!presetn) ##1 (force_input == $past(pe_q)))
      else $error("input direction not forced");

   chk_sync_two_stage:
   assert property (@(posedge pclk) disable iff (!presetn)
      (up_q == 2'h3) |-> (sif.synced == $past(key_pins, 2)))
      else $error("synchroniser latency wrong");

endmodule : kpi_keypad_pin_interrupt

/* File: verilog/kpi_defines.svh */
/*
 Register offsets, field positions, reset values and timing counts for the
 keypad pin interrupt unit. Assumes a byte-addressed APB with 32-bit data.
*/
`ifndef KPI_DEFINES_SVH
`define KPI_DEFINES_SVH

`define KPI_OFF_SC 8'h00
`define KPI_OFF_PE 8'h04
`define KPI_OFF_IST 8'h08
`define KPI_OFF_ICLR 8'h0C
`define KPI_OFF_IEN 8'h10

`define KPI_SC_POL_HI 7
`define KPI_SC_POL_LO 4
`define KPI_SC_FLAG_BIT 3
`define KPI_SC_ACK_BIT 2
`define KPI_SC_IE_BIT 1
`define KPI_SC_MODE_BIT 0

`define KPI_IST_EDGE_BIT 0
`define KPI_IST_WAKE_BIT 1

`define KPI_RST_POL 4'h0
`define KPI_RST_PE 8'h00
`define KPI_RST_IEN 2'h0
`define KPI_RST_SC_BIT 1'b0

`define KPI_SYNC_STAGES 2

`endif

/* File: verilog/kpi_pkg.sv */
/*
 Types shared by the keypad pin interrupt unit.
 Assumes kpi_defines.svh supplies all numeric constants.
*/
package kpi_pkg;
   typedef logic [7:0] kpi_pins_t;
   typedef enum {
      KPI_REG_SC,
      KPI_REG_PE,
      KPI_REG_IST,
      KPI_REG_ICLR,
      KPI_REG_IEN,
      KPI_REG_NONE
   } kpi_reg_t;
endpackage : kpi_pkg

/* File: verilog/kpi_sync_if.sv */
/*
 Carrier between the core and its pin synchroniser.
 Assumes both ends sit in the pclk domain.
*/
`timescale 1ns/1ps
interface kpi_sync_if;
   kpi_pkg::kpi_pins_t raw;
   kpi_pkg::kpi_pins_t synced;
   modport sync_side (input raw, output synced);
   modport core_side (output raw, input synced);
endinterface : kpi_sync_if

/* File: verilog/kpi_sync.sv */
/*
 Two-stage synchroniser for the eight key inputs.
 Assumes raw pins may change at any time relative to pclk.
*/
`timescale 1ns/1ps
module kpi_sync (
   input wire logic pclk,
   input wire logic presetn,
   kpi_sync_if.sync_side sif
);
   kpi_pkg::kpi_pins_t meta_q;
   kpi_pkg::kpi_pins_t stab_q;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q[i] <= 1'b0;
               stab_q[i] <= 1'b0;
            end else begin
               // First stage feeds only the second
               meta_q[i] <= sif.raw[i];
               stab_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sif.synced = stab_q;
endmodule : kpi_sync

/* File: test/kpi_key_model.sv */
/*
 Behavioural model of the key switches on the eight key inputs.
 Assumes the bench gives the wanted pin levels; the model drives them
 one pclk edge later, as a switch settling after a press.
*/
`timescale 1ns/1ps
module kpi_key_model (
   input wire logic pclk,
   input wire logic [7:0] want,
   output logic [7:0] key_level
);
   // No bounce modelled; the core sees one clean change per command
   always_ff @(posedge pclk) begin
      key_level <= want;
   end
endmodule : kpi_key_model

/* File: test/kpi_keypad_pin_interrupt_tb.sv */
/*
 Self-checking bench for the keypad pin interrupt unit: APB tasks and
 sequences of register and pin operations with expected values.
 Assumes the offsets and field positions of kpi_defines.svh.
*/
`timescale 1ns/1ps
`include "kpi_defines.svh"
module kpi_keypad_pin_interrupt_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic deep_sleep_state = 1'b0;
   logic [7:0] port_pull_en = 8'hFF;
   logic [7:0] want = 8'hFF;
   logic [7:0] key_pins;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic pready, pslverr, rerr, key_irq_req, irq, wake_req;
   logic [7:0] pull_down_sel, force_input;
   int fail_count = 0;
   int n_compared = 0;

   kpi_key_model i_keys (.pclk(pclk), .want(want), .key_level(key_pins));

   kpi_keypad_pin_interrupt i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_pins(key_pins),
      .deep_sleep_state(deep_sleep_state), .port_pull_en(port_pull_en),
      .key_irq_req(key_irq_req), .irq(irq), .pull_down_sel(pull_down_sel),
      .force_input(force_input), .wake_req(wake_req));

   always #5 pclk = ~pclk;

   task final_report;
      if (fail_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // Called just after an edge; leaves one idle edge so psel never toggles twice
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      if (n >= 20) chk(32'h0, 32'h1, "pready missing");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Model, sync, flag and request latency is five edges in all
   task pins(input logic [7:0] v);
      want <= v;
      repeat (6) @(posedge pclk);
   endtask : pins

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_0000, "sc reset");
      apb(0, `KPI_OFF_PE, 0);
      chk(rdat, 32'h0000_0000, "pe reset");
      apb(0, 8'h14, 0);
      chk(rerr, 32'h1, "unmapped error");
      apb(1, `KPI_OFF_PE, 32'h0000_00FF);
      apb(1, `KPI_OFF_SC, 32'h0000_0002);
      pins(8'hFE);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_000A, "falling edge flag");
      chk(key_irq_req, 32'h1, "request with enable");
      chk(force_input, 32'h0000_00FF, "forced input");
      chk(pull_down_sel, 32'h0000_0000, "no pulldown low sense");
      apb(1, `KPI_OFF_SC, 32'h0000_0006);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_0002, "ack clears in edge mode");
      pins(8'hFF);
      apb(1, `KPI_OFF_PE, 32'h0000_00FE);
      pins(8'hFE);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_0002, "disabled pin ignored");
      pins(8'hFF);
      // Polarity flips only with the pin disabled, else it reads as an edge
      apb(1, `KPI_OFF_PE, 32'h0000_0000);
      apb(1, `KPI_OFF_SC, 32'h0000_0080);
      apb(1, `KPI_OFF_PE, 32'h0000_0080);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_0080, "already asserted pin");
      chk(pull_down_sel, 32'h0000_0080, "pulldown high sense");
      pins(8'h7F);
      pins(8'hFF);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_0088, "rising edge flag");
      chk(key_irq_req, 32'h0, "no request when disabled");
      apb(1, `KPI_OFF_SC, 32'h0000_0084);
      pins(8'h7F);
      apb(1, `KPI_OFF_SC, 32'h0000_0081);
      pins(8'hFF);
      apb(1, `KPI_OFF_SC, 32'h0000_0085);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_0089, "level holds flag");
      pins(8'h7F);
      apb(1, `KPI_OFF_SC, 32'h0000_0085);
      apb(0, `KPI_OFF_SC, 0);
      chk(rdat, 32'h0000_0081, "ack after release");
      // Level mode: pin 0 held low, then pin 7 rises; no new edge event
      apb(1, `KPI_OFF_PE, 32'h0000_0081);
      pins(8'h7E);
      apb(1, `KPI_OFF_ICLR, 32'h0000_0001);
      pins(8'hFE);
      apb(0, `KPI_OFF_IST, 0);
      chk(rdat, 32'h0000_0000, "edge while other pin held");
      pins(8'h7F);
      apb(1, `KPI_OFF_SC, 32'h0000_0000);
      apb(1, `KPI_OFF_PE, 32'h0000_0001);
      apb(1, `KPI_OFF_ICLR, 32'h0000_0003);
      apb(1, `KPI_OFF_IEN, 32'h0000_0001);
      pins(8'hFF);
      pins(8'hFE);
      chk(irq, 32'h1, "irq raised");
      apb(0, `KPI_OFF_IST, 0);
      chk(rdat, 32'h0000_0001, "status sticky");
      apb(1, `KPI_OFF_IEN, 32'h0000_0000);
      // Request register lags the enable by one edge
      @(posedge pclk);
      chk(irq, 32'h0, "irq masked");
      apb(1, `KPI_OFF_ICLR, 32'h0000_0001);
      apb(0, `KPI_OFF_IST, 0);
      chk(rdat, 32'h0000_0000, "status cleared");
      apb(0, `KPI_OFF_ICLR, 0);
      chk(rdat, 32'h0000_0000, "clear reads zero");
      pins(8'hFF);
      chk(wake_req, 32'h0, "no wake awake");
      deep_sleep_state <= 1'b1;
      pins(8'hFE);
      chk(wake_req, 32'h1, "level wake in sleep");
      deep_sleep_state <= 1'b0;
      @(posedge pclk);
      final_report();
   end

   // Whole run is near 2400 ns
   initial begin
      #50000;
      fail_count++;
      final_report();
   end
endmodule : kpi_keypad_pin_interrupt_tb
